// file: rtl/slv_vec1.sv
`timescale 1ns/10ps
// line-one interrupt vector block with its own flag/enable/level slice
module slv_vec1 (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] evt_i,      // async event pulses/levels: bit0 err, bit1 rx, bit2 ovr
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_line1_o,          // line one request level
  output logic irq_o                 // masked status level
);
  logic [2:0] evt_s;                 // synchronised events
  logic [2:0] evt_d_ff;              // previous sample for edge detect
  logic [2:0] flag_ff;               // sticky event flags
  logic [2:0] ena_ff;                // source enables
  logic [2:0] lvl_ff;                // line select bits
  logic [2:0] mask_ff;               // irq_o mask
  logic [2:0] cand;                  // line-one candidates
  logic [4:0] code;                  // current vector
  logic [2:0] set_v;                 // rising edges of events
  logic [2:0] rd_clr;                // flags cleared by vector read
  logic [2:0] wr_clr;                // flags cleared by write one
  logic [2:0] nxt_flag;
  logic [31:0] nxt_rdata;

  // pin events cross into sys_clk first
  slv_sync #(.W(3)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(evt_i),
    .q_o(evt_s)
  );

  // candidates must be flagged, enabled and routed to line one
  assign cand = flag_ff & ena_ff & lvl_ff;

  slv_prio u_prio (
    .cand_i(cand),
    .code_o(code)
  );

  assign set_v = evt_s & ~evt_d_ff;

  // vector read clears overrun or receive only, never error
  always_comb
  begin
    rd_clr = 3'h0;
    if (rd_i && addr_i == slv_pkg::VEC1_OFF)
    begin
      if (code == slv_pkg::CODE_OVR) rd_clr[slv_pkg::SRC_OVR] = 1'b1;
      else if (code == slv_pkg::CODE_RX) rd_clr[slv_pkg::SRC_RX] = 1'b1;
    end
  end

  assign wr_clr = (wr_i && addr_i == slv_pkg::FLAG_OFF) ? wdata_i[2:0] : 3'h0;
  // set beats clear in the same cycle; next code appears the cycle after a read
  assign nxt_flag = (flag_ff & ~rd_clr & ~wr_clr) | set_v;

  // edge-detect history
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i) evt_d_ff <= slv_pkg::RST_SRC;
    else if (ce_i) evt_d_ff <= evt_s;
  end

  // sticky flags
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i) flag_ff <= slv_pkg::RST_SRC;
    else if (ce_i) flag_ff <= nxt_flag;
  end

  // control registers written by software
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ena_ff <= slv_pkg::RST_SRC;
      lvl_ff <= slv_pkg::RST_SRC;
      mask_ff <= slv_pkg::RST_SRC;
    end
    else if (ce_i && wr_i)
    begin
      // vector word has no writable bits at all
      case (addr_i)
        slv_pkg::ENA_OFF: ena_ff <= wdata_i[2:0];
        slv_pkg::LVL_OFF: lvl_ff <= wdata_i[2:0];
        slv_pkg::MASK_OFF: mask_ff <= wdata_i[2:0];
        default: ;
      endcase
    end
  end

  // read mux, unmapped reads as zero
  always_comb
  begin
    nxt_rdata = slv_pkg::RST_WORD;
    case (addr_i)
      slv_pkg::VEC1_OFF: nxt_rdata[slv_pkg::VEC_LSB +: slv_pkg::VEC_W] = code;
      slv_pkg::FLAG_OFF: nxt_rdata[2:0] = flag_ff;
      slv_pkg::ENA_OFF: nxt_rdata[2:0] = ena_ff;
      slv_pkg::LVL_OFF: nxt_rdata[2:0] = lvl_ff;
      slv_pkg::MASK_OFF: nxt_rdata[2:0] = mask_ff;
      default: nxt_rdata = slv_pkg::RST_WORD;
    endcase
  end

  // registered outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= slv_pkg::RST_WORD;
      irq_line1_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_o <= rd_i ? nxt_rdata : slv_pkg::RST_WORD;
      irq_line1_o <= |(nxt_flag & ena_ff & lvl_ff);
      irq_o <= |(nxt_flag & mask_ff);
    end
  end
endmodule : slv_vec1

// file: rtl/slv_pkg.sv
package slv_pkg;
  // register map of this slice
  localparam logic [7:0] VEC1_OFF = 8'h00;      // line-one vector word
  localparam logic [7:0] FLAG_OFF = 8'h04;      // sticky event flags, write one clears
  localparam logic [7:0] ENA_OFF = 8'h08;       // source enables
  localparam logic [7:0] LVL_OFF = 8'h0C;       // line select, 1 = line one
  localparam logic [7:0] MASK_OFF = 8'h10;      // irq mask for irq_o
  // field layout
  localparam int VEC_LSB = 1;
  localparam int VEC_W = 5;
  localparam int NSRC = 3;
  // source bit positions within flag/enable/level words
  localparam int SRC_ERR = 0;
  localparam int SRC_RX = 1;
  localparam int SRC_OVR = 2;
  // vector codes
  localparam logic [4:0] CODE_NONE = 5'h00;
  localparam logic [4:0] CODE_ERR = 5'h11;
  localparam logic [4:0] CODE_RX = 5'h12;
  localparam logic [4:0] CODE_OVR = 5'h13;
  // reset values
  localparam logic [2:0] RST_SRC = 3'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : slv_pkg

// file: rtl/slv_prio.sv
`timescale 1ns/10ps
// fixed-priority encoder from candidate set to vector code
module slv_prio (
  input wire logic [2:0] cand_i,
  output logic [4:0] code_o
);
  // overrun wins, then receive, then error
  always_comb
  begin
    if (cand_i[slv_pkg::SRC_OVR]) code_o = slv_pkg::CODE_OVR;
    else if (cand_i[slv_pkg::SRC_RX]) code_o = slv_pkg::CODE_RX;
    else if (cand_i[slv_pkg::SRC_ERR]) code_o = slv_pkg::CODE_ERR;
    else code_o = slv_pkg::CODE_NONE;
  end
endmodule : slv_prio

// file: rtl/slv_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser per bit for event pins
module slv_sync #(
  parameter int W = 3
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_ff; // first stage, read only by second
  // second stage feeds all logic
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= '0;
      q_o <= '0;
    end
    else if (ce_i)
    begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule : slv_sync

// file: verif/slv_vec1_props.sv
`timescale 1ns/10ps
// sees ports only: flags are hidden, so codes are tied to the line level
module slv_vec1_props (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [2:0] evt_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_line1_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire logic [4:0] cd = rdata_o[5:1]; // vector field
  wire logic vr = ce_i && rd_i && addr_i == 8'h00; // vector read taken
  property p_hi; rdata_o[31:6] == 26'h0; endproperty
  a_hi: assert property (p_hi) else $error("high bits set");
  property p_b0; !rdata_o[0]; endproperty
  a_b0: assert property (p_b0) else $error("bit 0 set");
  property p_cd; cd inside {5'h00, 5'h11, 5'h12, 5'h13}; endproperty
  a_cd: assert property (p_cd) else $error("bad code");
  // the line level one cycle before the data matches the code, unless a write landed just before the read
  property p_ln; $past(vr) && !$past(wr_i, 2) |-> (cd != 5'h00) == $past(irq_line1_o); endproperty
  a_ln: assert property (p_ln) else $error("code vs line");
  property p_er; $past(vr) && cd == 5'h11 |=> irq_line1_o; endproperty
  a_er: assert property (p_er) else $error("error cleared");
  property p_id; $past(ce_i && !rd_i) |-> rdata_o == '0; endproperty
  a_id: assert property (p_id) else $error("data without read");
  property p_um; $past(ce_i && rd_i && addr_i > 8'h10) |-> rdata_o == '0; endproperty
  a_um: assert property (p_um) else $error("unmapped data");
  property p_rs; $past(ce_i && rst_i) |-> !(rdata_o || irq_o || irq_line1_o); endproperty
  a_rs: assert property (p_rs) else $error("reset state");
endmodule : slv_vec1_props

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic sys_clk_i = 1'b0;
  logic rst_i, ce_i, wr_i, rd_i, irq_line1_o, irq_o;
  logic [2:0] evt_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  int failures = 0;
  int samples_checked = 0;
  slv_vec1 dut_u (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .evt_i(evt_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .irq_line1_o(irq_line1_o),
    .irq_o(irq_o)
  );
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    failures += int'(g !== e);
    if (g !== e) $display("unexpected %s exp %h got %h", n, e, g);
  endtask : chk
  // one strobe cycle; read data checked in the cycle after only
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
    @(posedge sys_clk_i);
    {wr_i, rd_i} <= 2'h0;
    if (!w) #1 chk("rdata", d, rdata_o);
  endtask : bus
  task automatic tally_and_finish(input int hung);
    failures += hung;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // run needs about 65 cycles
  initial #4000 tally_and_finish(1);
  initial
  begin
    {rst_i, ce_i, wr_i, rd_i, evt_i, addr_i, wdata_i} = {2'h3, 45'h0};
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    bus(1'h1, 8'h08, 32'h0000_0007);
    // all three sources at once, none routed yet
    @(posedge sys_clk_i) evt_i <= 3'h7;
    repeat (6) @(posedge sys_clk_i);
    #1 chk("irq", 32'h0000_0000, {irq_line1_o, irq_o});
    bus(1'h1, 8'h0C, 32'h0000_0007);
    bus(1'h1, 8'h10, 32'h0000_0007);
    repeat (2) @(posedge sys_clk_i);
    #1 chk("irq", 32'h0000_0003, {irq_line1_o, irq_o});
    bus(1'h0, 8'h00, 32'h0000_0026);
    bus(1'h0, 8'h00, 32'h0000_0024);
    bus(1'h0, 8'h00, 32'h0000_0022);
    bus(1'h0, 8'h00, 32'h0000_0022);
    bus(1'h1, 8'h04, 32'h0000_0001);
    bus(1'h1, 8'h00, 32'hFFFF_FFFF);
    bus(1'h0, 8'h00, 32'h0000_0000);
    bus(1'h0, 8'h40, 32'h0000_0000);
    chk("irq", 32'h0000_0000, {irq_line1_o, irq_o});
    $display("test vector done");
    // clock enable low freezes the event path, including the synchroniser
    @(posedge sys_clk_i) evt_i <= 3'h0;
    repeat (4) @(posedge sys_clk_i);
    ce_i <= 1'b0;
    evt_i <= 3'h2;
    repeat (8) @(posedge sys_clk_i);
    #1 chk("irq_frozen", 32'h0000_0000, {irq_line1_o, irq_o});
    @(posedge sys_clk_i) ce_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1 chk("irq", 32'h0000_0003, {irq_line1_o, irq_o});
    bus(1'h0, 8'h00, 32'h0000_0024);
    chk("irq", 32'h0000_0000, {irq_line1_o, irq_o});
    $display("test freeze done");
    // reset in mid-run returns control registers to zero
    @(posedge sys_clk_i) rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    bus(1'h0, 8'h08, 32'h0000_0000);
    bus(1'h0, 8'h00, 32'h0000_0000);
    chk("irq", 32'h0000_0000, {irq_line1_o, irq_o});
    $display("test reset done");
    tally_and_finish(0);
  end
endmodule : tb
bind slv_vec1 slv_vec1_props chk_u (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .ce_i(ce_i),
  .evt_i(evt_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .irq_line1_o(irq_line1_o),
  .irq_o(irq_o)
);
